// ==== pll_prog_pkg.sv ====
// Constants and types shared by the serial programming and power-down logic
package pll_prog_pkg;

  // Serial word layout
  localparam int WORD_BITS = 22;
  localparam int DATA_BITS = 20;
  localparam int ADDR_BITS = 2;
  localparam int DATA_LSB = 2;

  // Address field codes
  localparam logic [1:0] ADDR_REF = 2'h0;
  localparam logic [1:0] ADDR_FB = 2'h1;
  localparam logic [1:0] ADDR_TIMEOUT = 2'h2;

  // Reference register fields, as word bit numbers
  localparam int REF_MUX1_BIT = 21;
  localparam int REF_MUX0_BIT = 20;
  localparam int REF_FLOAT_BIT = 19;
  localparam int REF_BOOST_BIT = 18;
  localparam int REF_POL_BIT = 17;
  localparam int REF_DIV_MSB = 16;
  localparam int REF_DIV_LSB = 2;

  // Feedback register fields
  localparam int FB_POWERDOWN_BIT_BIT = 21;
  localparam int FB_PRESCALE_BIT = 20;
  localparam int FB_COARSE_MSB = 19;
  localparam int FB_COARSE_LSB = 7;
  localparam int FB_SWALLOW_MSB = 6;
  localparam int FB_SWALLOW_LSB = 2;

  // Timeout register fields
  localparam int TO_MUX2_BIT = 14;
  localparam int TO_COUNT_MSB = 13;
  localparam int TO_COUNT_LSB = 2;

  // Values after reset
  localparam logic [19:0] CTRL_RESET = 20'h0_0000;
  localparam logic [21:0] SHIFT_RESET = 22'h00_0000;

  // Divider hold after power-up
  localparam int CLK_PERIOD_PS = 10000;
  localparam int WAKE_HOLD_PS = 1500000;
  localparam int WAKE_CYCLES =
    (WAKE_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WAKE_CNT_W = 8;

  // Requested operating mode
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_SYNC_PD = 3'b010,
    MODE_ASYNC_PD = 3'b100
  } pd_mode_t;

  // Power sequencer states
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_SYNC_WAIT = 4'b0010,
    ST_DOWN = 4'b0100,
    ST_WAKE = 4'b1000
  } pwr_state_t;

endpackage

// ==== serial_word_shifter.sv ====
// Three-wire serial receiver: shifts a word and presents it on latch
module serial_word_shifter #(
  parameter int WORD_W = 22
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic serialClkPin,
  input wire logic serialDataPin,
  input wire logic latchStrobePin,
  output logic wordValid,
  output logic [WORD_W-1:0] wordOut
);
  import pll_prog_pkg::*;

  // Bit 0 clock, bit 1 data, bit 2 latch strobe
  logic [2:0] pinMeta_r;
  logic [2:0] pinSync_r;
  logic [2:0] pinPrev_r;
  logic [WORD_W-1:0] shift_r;
  logic [WORD_W-1:0] shift_nxt;
  logic [WORD_W-1:0] word_r;
  logic [WORD_W-1:0] word_nxt;
  logic valid_r;
  logic valid_nxt;
  logic clkRise;
  logic latchRise;

  assign clkRise = pinSync_r[0] & ~pinPrev_r[0];
  assign latchRise = pinSync_r[2] & ~pinPrev_r[2];

  always_comb begin
    shift_nxt = shift_r;
    word_nxt = word_r;
    valid_nxt = 1'b0;
    // MSB arrives first, so it ends up at the top after all bits
    if (clkRise) begin
      shift_nxt = {shift_r[WORD_W-2:0], pinSync_r[1]};
    end
    // Shift keeps running in every power mode
    if (latchRise) begin
      word_nxt = shift_r;
      valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pinMeta_r <= 3'b000;
      pinSync_r <= 3'b000;
      pinPrev_r <= 3'b000;
      shift_r <= SHIFT_RESET[WORD_W-1:0];
      word_r <= SHIFT_RESET[WORD_W-1:0];
      valid_r <= 1'b0;
    end else begin
      pinMeta_r <= {latchStrobePin, serialDataPin, serialClkPin};
      pinSync_r <= pinMeta_r;
      pinPrev_r <= pinSync_r;
      shift_r <= shift_nxt;
      word_r <= word_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign wordValid = valid_r;
  assign wordOut = word_r;

endmodule

// ==== pll_program_powerdown.sv ====
// Serial control registers and power-down sequencer of the synthesizer
module pll_program_powerdown (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic serialClkPin,
  input wire logic serialDataPin,
  input wire logic latchStrobePin,
  input wire logic chipEnablePin,
  input wire logic pumpUpRaw,
  input wire logic pumpDownRaw,
  output logic muxoutSelect_0,
  output logic muxoutSelect_1,
  output logic muxoutSelect_2,
  output logic pumpFloatBit,
  output logic pumpBoostBit,
  output logic detectorPolarityBit,
  output logic [14:0] refDivideValue,
  output logic powerdownBit,
  output logic prescalerSelect,
  output logic [12:0] fbCoarseCount,
  output logic [4:0] fbSwallowCount,
  output logic [11:0] timeoutCount,
  output logic [3:0] circuitEnable,
  output logic [3:0] padHighZ,
  output logic refDivEnable,
  output logic fbDivEnable,
  output logic pumpUp,
  output logic pumpDown,
  output logic poweredDown
);
  import pll_prog_pkg::*;

  function automatic pd_mode_t modeDecode(input logic ce,
                                          input logic powerdown_bit,
                                          input logic fl);
    pd_mode_t m;
    m = MODE_NORMAL;
    if (!ce) begin
      m = MODE_ASYNC_PD;
    end else if (powerdown_bit && fl) begin
      m = MODE_ASYNC_PD;
    end else if (powerdown_bit) begin
      m = MODE_SYNC_PD;
    end
    return m;
  endfunction

  localparam logic [WAKE_CNT_W-1:0] WAKE_LAST =
    WAKE_CNT_W'(WAKE_CYCLES - 1);

  // Serial receiver
  logic wordValid;
  logic [WORD_BITS-1:0] wordIn;
  logic [DATA_BITS-1:0] wordData;
  logic [ADDR_BITS-1:0] wordAddr;

  serial_word_shifter #(
    .WORD_W(WORD_BITS)
  ) shifter (
    .mclk(mclk),
    .nrst(nrst),
    .serialClkPin(serialClkPin),
    .serialDataPin(serialDataPin),
    .latchStrobePin(latchStrobePin),
    .wordValid(wordValid),
    .wordOut(wordIn)
  );

  assign wordData = wordIn[WORD_BITS-1:DATA_LSB];
  assign wordAddr = wordIn[ADDR_BITS-1:0];

  // Control registers
  logic [DATA_BITS-1:0] refCtrl_r;
  logic [DATA_BITS-1:0] refCtrl_nxt;
  logic [DATA_BITS-1:0] fbCtrl_r;
  logic [DATA_BITS-1:0] fbCtrl_nxt;
  logic [DATA_BITS-1:0] toCtrl_r;
  logic [DATA_BITS-1:0] toCtrl_nxt;

  always_comb begin
    refCtrl_nxt = refCtrl_r;
    fbCtrl_nxt = fbCtrl_r;
    toCtrl_nxt = toCtrl_r;
    // Address 3 selects nothing; such a word is dropped
    if (wordValid && wordAddr == ADDR_REF) begin
      refCtrl_nxt = wordData;
    end else if (wordValid && wordAddr == ADDR_FB) begin
      fbCtrl_nxt = wordData;
    end else if (wordValid && wordAddr == ADDR_TIMEOUT) begin
      toCtrl_nxt = wordData;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      refCtrl_r <= CTRL_RESET;
      fbCtrl_r <= CTRL_RESET;
      toCtrl_r <= CTRL_RESET;
    end else begin
      refCtrl_r <= refCtrl_nxt;
      fbCtrl_r <= fbCtrl_nxt;
      toCtrl_r <= toCtrl_nxt;
    end
  end

  // Field views of the stored data
  logic cfgFloat;
  logic cfgPol;
  logic cfgPwdn;

  assign cfgFloat = refCtrl_r[REF_FLOAT_BIT-DATA_LSB];
  assign cfgPol = refCtrl_r[REF_POL_BIT-DATA_LSB];
  assign cfgPwdn = fbCtrl_r[FB_POWERDOWN_BIT_BIT-DATA_LSB];

  assign muxoutSelect_1 = refCtrl_r[REF_MUX1_BIT-DATA_LSB];
  assign muxoutSelect_0 = refCtrl_r[REF_MUX0_BIT-DATA_LSB];
  assign pumpFloatBit = cfgFloat;
  assign pumpBoostBit = refCtrl_r[REF_BOOST_BIT-DATA_LSB];
  assign detectorPolarityBit = cfgPol;
  assign refDivideValue =
    refCtrl_r[REF_DIV_MSB-DATA_LSB:REF_DIV_LSB-DATA_LSB];
  assign powerdownBit = cfgPwdn;
  assign prescalerSelect =
    fbCtrl_r[FB_PRESCALE_BIT-DATA_LSB];
  assign fbCoarseCount =
    fbCtrl_r[FB_COARSE_MSB-DATA_LSB:FB_COARSE_LSB-DATA_LSB];
  assign fbSwallowCount =
    fbCtrl_r[FB_SWALLOW_MSB-DATA_LSB:FB_SWALLOW_LSB-DATA_LSB];
  // Upper timeout bits are not decoded; host writes them as zero
  assign muxoutSelect_2 = toCtrl_r[TO_MUX2_BIT-DATA_LSB];
  assign timeoutCount =
    toCtrl_r[TO_COUNT_MSB-DATA_LSB:TO_COUNT_LSB-DATA_LSB];

  // Chip enable pin synchroniser
  logic ceMeta_r;
  logic ceSync_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ceMeta_r <= 1'b0;
      ceSync_r <= 1'b0;
    end else begin
      ceMeta_r <= chipEnablePin;
      ceSync_r <= ceMeta_r;
    end
  end

  // Power sequencer
  pd_mode_t mode;
  pwr_state_t state_r;
  pwr_state_t state_nxt;
  logic [WAKE_CNT_W-1:0] wakeCnt_r;
  logic [WAKE_CNT_W-1:0] wakeCnt_nxt;
  logic pulseSeen_r;
  logic pulseSeen_nxt;
  logic pumpBusy;

  assign mode = modeDecode(ceSync_r, cfgPwdn, cfgFloat);
  assign pumpBusy = pumpUp | pumpDown;

  always_comb begin
    state_nxt = state_r;
    wakeCnt_nxt = wakeCnt_r;
    pulseSeen_nxt = pulseSeen_r;
    case (state_r)
      ST_RUN: begin
        pulseSeen_nxt = pumpBusy;
        if (mode == MODE_ASYNC_PD) begin
          state_nxt = ST_DOWN;
        end else if (mode == MODE_SYNC_PD) begin
          state_nxt = ST_SYNC_WAIT;
        end
      end
      ST_SYNC_WAIT: begin
        // A pulse already running counts; enter after its falling edge
        if (pumpBusy) begin
          pulseSeen_nxt = 1'b1;
        end
        if (mode == MODE_ASYNC_PD) begin
          state_nxt = ST_DOWN;
        end else if (mode == MODE_NORMAL) begin
          state_nxt = ST_RUN;
        end else if (pulseSeen_r && !pumpBusy) begin
          state_nxt = ST_DOWN;
        end
      end
      ST_DOWN: begin
        pulseSeen_nxt = 1'b0;
        wakeCnt_nxt = '0;
        if (mode == MODE_NORMAL) begin
          state_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // No pump pulses after the first cycle here, so any power-down goes straight down
        if (mode != MODE_NORMAL) begin
          state_nxt = ST_DOWN;
        end else if (wakeCnt_r == WAKE_LAST) begin
          state_nxt = ST_RUN;
        end else begin
          wakeCnt_nxt = wakeCnt_r + 1'b1;
        end
      end
      default: begin
        state_nxt = ST_DOWN;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_DOWN;
      wakeCnt_r <= '0;
      pulseSeen_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wakeCnt_r <= wakeCnt_nxt;
      pulseSeen_r <= pulseSeen_nxt;
    end
  end

  // Registered power controls, taken from the next state
  logic analogOn;
  logic divRun;
  logic [3:0] circuitEnable_r;
  logic [3:0] circuitEnable_nxt;
  logic [3:0] padHighZ_r;
  logic [3:0] padHighZ_nxt;
  logic divEnable_r;
  logic divEnable_nxt;
  logic pumpUp_r;
  logic pumpUp_nxt;
  logic pumpDown_r;
  logic pumpDown_nxt;
  logic down_r;
  logic down_nxt;

  assign analogOn = (state_nxt != ST_DOWN);
  assign divRun = (state_nxt == ST_RUN) || (state_nxt == ST_SYNC_WAIT);

  always_comb begin
    // Bits: 0 osc buffer, 1 prescaler, 2 detector, 3 charge pump
    circuitEnable_nxt = {4{analogOn}};
    // Bits: 0 ref input, 1 pump output, 2 RF inputs, 3 lock pin
    padHighZ_nxt = {4{!analogOn}};
    // One flop feeds both enables so the restart lines up
    divEnable_nxt = divRun;
    down_nxt = !analogOn;
    pumpUp_nxt = 1'b0;
    pumpDown_nxt = 1'b0;
    // Pump stays quiet while floated or while dividers are held, except in the first wake cycle
    if (analogOn && !cfgFloat && state_r != ST_WAKE) begin
      if (cfgPol) begin
        pumpUp_nxt = pumpUpRaw;
        pumpDown_nxt = pumpDownRaw;
      end else begin
        pumpUp_nxt = pumpDownRaw;
        pumpDown_nxt = pumpUpRaw;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      circuitEnable_r <= 4'h0;
      padHighZ_r <= 4'hF;
      divEnable_r <= 1'b0;
      pumpUp_r <= 1'b0;
      pumpDown_r <= 1'b0;
      down_r <= 1'b1;
    end else begin
      circuitEnable_r <= circuitEnable_nxt;
      padHighZ_r <= padHighZ_nxt;
      divEnable_r <= divEnable_nxt;
      pumpUp_r <= pumpUp_nxt;
      pumpDown_r <= pumpDown_nxt;
      down_r <= down_nxt;
    end
  end

  assign circuitEnable = circuitEnable_r;
  assign padHighZ = padHighZ_r;
  assign refDivEnable = divEnable_r;
  assign fbDivEnable = divEnable_r;
  assign pumpUp = pumpUp_r;
  assign pumpDown = pumpDown_r;
  assign poweredDown = down_r;

endmodule

// ==== serial_host.sv ====
// Host model that shifts words into the serial programming port
module serial_host (
  output logic serialClk,
  output logic serialData,
  output logic latchStrobe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    serialClk = 1'b0;
    serialData = 1'b0;
    latchStrobe = 1'b0;
  end
  // Clock stands low outside frames; 160 ns period
  task automatic send(input logic [21:0] w);
    for (int i = 21; i >= 0; i--) begin
      serialData = w[i];
      #80 serialClk = 1'b1;
      #80 serialClk = 1'b0;
    end
    // Data no longer held, so show the inverse of the last bit
    serialData = ~w[0];
    #80 latchStrobe = 1'b1;
    #80 latchStrobe = 1'b0;
    #80;
  endtask
endmodule

// ==== pll_program_powerdown_props.sv ====
// Checker for the programming and power-down block
module pll_program_powerdown_props (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic latchStrobePin,
  input wire logic chipEnablePin,
  input wire logic pumpUpRaw,
  input wire logic pumpDownRaw,
  input wire logic pumpFloatBit,
  input wire logic detectorPolarityBit,
  input wire logic powerdownBit,
  input wire logic [11:0] timeoutCount,
  input wire logic [3:0] circuitEnable,
  input wire logic [3:0] padHighZ,
  input wire logic refDivEnable,
  input wire logic fbDivEnable,
  input wire logic pumpUp,
  input wire logic pumpDown,
  input wire logic poweredDown
);
  timeunit 1ns;
  timeprecision 100ps;
  import pll_prog_pkg::*;
  logic [7:0] holdCnt_r;
  logic [7:0] holdCnt_nxt;
  logic pumpAny;
  // Counts powered cycles with dividers held; saturates, never wraps
  always_comb begin
    pumpAny = pumpUp | pumpDown;
    holdCnt_nxt = 8'h00;
    if (circuitEnable == 4'hF && !refDivEnable) begin
      holdCnt_nxt = (holdCnt_r == 8'hFF) ? holdCnt_r : holdCnt_r + 8'h01;
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      holdCnt_r <= 8'h00;
    end else begin
      holdCnt_r <= holdCnt_nxt;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  chk_ce_low: assert property (
    !chipEnablePin [*4] |-> poweredDown)
    else $error("chip enable low but not powered down");
  chk_async_bits: assert property (
    powerdownBit && pumpFloatBit |=> poweredDown)
    else $error("async power-down late");
  chk_down_gates: assert property (
    poweredDown |-> circuitEnable == 4'h0 && padHighZ == 4'hF &&
      !refDivEnable && !pumpUp && !pumpDown)
    else $error("power-down outputs wrong");
  chk_div_together: assert property (
    refDivEnable == fbDivEnable)
    else $error("dividers enabled apart");
  chk_wake_hold: assert property (
    $rose(refDivEnable) |-> holdCnt_r == 8'(WAKE_CYCLES))
    else $error("divider hold length wrong");
  chk_wake_power: assert property (
    $fell(poweredDown) |-> circuitEnable == 4'hF && padHighZ == 4'h0)
    else $error("analog not powered on wake");
  chk_pump_sense: assert property (
    refDivEnable && !pumpFloatBit && pumpUpRaw && !pumpDownRaw |=>
      poweredDown || (pumpUp == $past(detectorPolarityBit) &&
      pumpDown == !$past(detectorPolarityBit)))
    else $error("pump polarity wrong");
  chk_float_gate: assert property (
    $past(pumpFloatBit) |-> !pumpUp && !pumpDown)
    else $error("pump active while floated");
  chk_sync_down: assert property (
    $fell(pumpAny) && $past(powerdownBit) && powerdownBit &&
      !pumpFloatBit |-> ##[0:2] poweredDown)
    else $error("sync power-down missed pulse end");
  chk_write_latch: assert property (
    $changed(timeoutCount) |-> $past(latchStrobePin, 4))
    else $error("register changed without latch");
  cover property ($fell(pumpAny) && powerdownBit && !pumpFloatBit);
  cover property ($rose(refDivEnable));
  cover property ($changed(timeoutCount));
endmodule

bind pll_program_powerdown pll_program_powerdown_props props (
  .mclk(mclk), .nrst(nrst), .latchStrobePin(latchStrobePin),
  .chipEnablePin(chipEnablePin), .pumpUpRaw(pumpUpRaw),
  .pumpDownRaw(pumpDownRaw), .pumpFloatBit(pumpFloatBit),
  .detectorPolarityBit(detectorPolarityBit), .powerdownBit(powerdownBit),
  .timeoutCount(timeoutCount), .circuitEnable(circuitEnable),
  .padHighZ(padHighZ), .refDivEnable(refDivEnable),
  .fbDivEnable(fbDivEnable), .pumpUp(pumpUp), .pumpDown(pumpDown),
  .poweredDown(poweredDown)
);

// ==== testbench.sv ====
// Self-checking bench for the programming and power-down block
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import pll_prog_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic ceBench = 1'b1;
  logic upRaw = 1'b0;
  logic downRaw = 1'b0;
  logic sClk, sData, sLatch, mux0, mux1, mux2, flt, boost, pol, powerdown_bit, pre;
  logic refEn, fbEn, pUp, pDn, down;
  logic [14:0] refDiv;
  logic [12:0] coarse;
  logic [4:0] swallow;
  logic [11:0] tout;
  logic [3:0] cirEn, hiZ;
  logic [21:0] rw = 22'h00_0000, nw = 22'h00_0000, tw = 22'h00_0000;
  wire [19:0] refFields = {mux1, mux0, flt, boost, pol, refDiv};
  wire [19:0] fbFields = {powerdown_bit, pre, coarse, swallow};
  wire [12:0] toFields = {mux2, tout};
  int fails = 0, total_checks = 0, cycles = 0;
  always #5 mclk = ~mclk;
  serial_host host (.serialClk(sClk), .serialData(sData),
    .latchStrobe(sLatch));
  pll_program_powerdown dut (.mclk(mclk), .nrst(nrst),
    .serialClkPin(sClk), .serialDataPin(sData), .latchStrobePin(sLatch),
    .chipEnablePin(ceBench), .pumpUpRaw(upRaw), .pumpDownRaw(downRaw),
    .muxoutSelect_0(mux0), .muxoutSelect_1(mux1), .muxoutSelect_2(mux2),
    .pumpFloatBit(flt), .pumpBoostBit(boost), .detectorPolarityBit(pol),
    .refDivideValue(refDiv), .powerdownBit(powerdown_bit), .prescalerSelect(pre),
    .fbCoarseCount(coarse), .fbSwallowCount(swallow), .timeoutCount(tout),
    .circuitEnable(cirEn), .padHighZ(hiZ), .refDivEnable(refEn),
    .fbDivEnable(fbEn), .pumpUp(pUp), .pumpDown(pDn), .poweredDown(down));
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic logic [19:0] rand_ref(logic [31:0] r);
    logic [19:0] d;
    d = r[19:0];
    if (d[14:0] < 15'h0002) begin
      d[14:0] = 15'h0002;
    end
    return d;
  endfunction
  // Shadow words mirror what each register should hold
  task automatic put(input logic [19:0] d, input logic [1:0] a);
    host.send({d, a});
    case (a)
      ADDR_REF: rw = {d, a};
      ADDR_FB: nw = {d, a};
      ADDR_TIMEOUT: tw = {d, a};
      default: ;
    endcase
    repeat (10) @(negedge mclk);
    check("refReg", refFields, rw[21:2]);
    check("fbReg", fbFields, nw[21:2]);
    check("toReg", toFields, tw[14:2]);
  endtask
  task automatic wake_check();
    repeat (100) @(negedge mclk);
    check("heldAtWake", {refEn, cirEn, hiZ}, 9'h0F0);
    repeat (60) @(negedge mclk);
    check("countingAfterWake", {refEn, fbEn}, 2'b11);
  endtask
  // Hang guard, well above the roughly 13000 cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    void'($urandom(1));
    repeat (6) @(negedge mclk);
    nrst = 1'b1;
    wake_check();
    for (int i = 0; i < 6; i++) begin
      put(rand_ref($urandom()), ADDR_REF);
      put({1'b0, 19'($urandom())}, ADDR_FB);
      put({7'h00, 13'($urandom())}, ADDR_TIMEOUT);
      put(20'($urandom()), 2'h3);
    end
    for (int p = 0; p < 2; p++) begin
      put({4'h0, p[0], 15'h0002}, ADDR_REF);
      upRaw = 1'b1;
      repeat (2) @(negedge mclk);
      check("pumpSense", {pUp, pDn}, {p[0], !p[0]});
      upRaw = 1'b0;
    end
    put({1'b1, 19'h0_0000}, ADDR_FB);
    check("noPulseNoDown", down, 1'b0);
    downRaw = 1'b1;
    repeat (4) @(negedge mclk);
    check("pulseNotDone", down, 1'b0);
    downRaw = 1'b0;
    repeat (4) @(negedge mclk);
    check("syncDown", {down, cirEn, hiZ, refEn}, 10'h21E);
    put(rand_ref($urandom()), ADDR_REF);
    put(20'h0_0000, ADDR_FB);
    wake_check();
    put({4'h2, 1'b1, 15'h0002}, ADDR_REF);
    upRaw = 1'b1;
    repeat (2) @(negedge mclk);
    check("floatGate", {pUp, pDn}, 2'b00);
    upRaw = 1'b0;
    put({1'b1, 19'h0_0000}, ADDR_FB);
    check("asyncDown", down, 1'b1);
    put(20'h0_0000, ADDR_FB);
    wake_check();
    ceBench = 1'b0;
    repeat (5) @(negedge mclk);
    check("ceLowDown", down, 1'b1);
    ceBench = 1'b1;
    wake_check();
    close_out();
  end
endmodule
